/* File: design/paf_front_end.sv */
/*
  Execution front end: decodes width prefix and pulse suffix, gates
  execution once per scan, and builds the source operand value.
  Assumes scan_strobe pulses one cycle per scan and that the register
  and bit-device stores outside answer combinationally on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Width prefix selects 32-bit, otherwise 16-bit
// - Pulse suffix selects edge execution
// - Pulse instruction fires one scan on rise
// - No re-execution while contact stays on
// - Continuous instruction fires every scan while on
// - Registers 16 bits; doubles use register pairs
// - Register n low word, n+1 high word
// - Counters 200-255 only for 32-bit
// - Group count spans 4n bits, bounded
// - Group bits consecutive from named device
// - 32-bit constants full signed range
// - Narrow group zero-fills upper bits
module paf_front_end #(
  parameter int unsigned SLOTS = 8
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          scan_strobe,
  input  wire logic [$clog2(SLOTS)-1:0]      instr_slot,
  input  wire logic                          width_prefix,
  input  wire logic                          pulse_suffix,
  input  wire logic                          drive_contact,
  input  wire paf_pkg::paf_src_t             src_sel,
  input  wire paf_pkg::paf_kind_t            src_kind,
  input  wire logic [31:0]                   const_value,
  input  wire logic [3:0]                    nibble_group_operand,
  input  wire logic [31:0]                   bit_devices,
  input  wire logic [15:0]                   reg_num,
  output logic [15:0]                        reg_rd_addr_lo,
  output logic [15:0]                        reg_rd_addr_hi,
  input  wire logic [15:0]                   reg_rd_data_lo,
  input  wire logic [15:0]                   reg_rd_data_hi,
  output logic                               exec,
  output logic                               is_double,
  output logic [31:0]                        operand,
  output logic                               operand_error
);

  // Refuse sizes and package values that the logic cannot serve
  if (SLOTS < 2) begin : g_slots_low
    $error("SLOTS must be at least two");
  end
  if ((SLOTS & (SLOTS - 1)) != 0) begin : g_slots_pow2
    $error("SLOTS must be a power of two");
  end
  if (paf_pkg::WORD_W * 2 != paf_pkg::DWORD_W) begin : g_pair_fit
    $error("A double word must be exactly two registers");
  end
  if (paf_pkg::GROUP_MAX_16 * paf_pkg::NIBBLE_W != paf_pkg::WORD_W) begin : g_group16_fit
    $error("The word group limit must fill one register");
  end
  if (paf_pkg::GROUP_MAX_32 * paf_pkg::NIBBLE_W != paf_pkg::DWORD_W) begin : g_group32_fit
    $error("The double group limit must fill the operand");
  end
  if (paf_pkg::GROUP_MAX_16 > paf_pkg::GROUP_MAX_32) begin : g_group_order
    $error("The word group limit cannot exceed the double limit");
  end
  if (paf_pkg::GROUP_CNT_W != 4) begin : g_count_port
    $error("GROUP_CNT_W must match the group count port");
  end
  if (paf_pkg::REG_NUM_W != 16) begin : g_reg_port
    $error("REG_NUM_W must match the register number port");
  end
  if (paf_pkg::CNT16_LAST + 16'h0001 != paf_pkg::CNT32_FIRST) begin : g_cnt_split
    $error("Narrow and wide counters must meet without a gap");
  end
  if (paf_pkg::CNT32_FIRST > paf_pkg::CNT32_LAST) begin : g_cnt_order
    $error("The wide counter range is empty");
  end

  typedef struct packed {
    logic [SLOTS-1:0] prev_on;
    logic             exec;
    logic             is_double;
    logic [31:0]      operand;
    logic             operand_error;
  } paf_state_t;

  paf_state_t st;
  paf_state_t next_st;
  // Operand building blocks
  logic [31:0]       reg_pair;
  logic [31:0]       const_ext;
  logic [31:0]       src_value;
  logic [3:0]        group_limit;
  logic              bad_group;
  logic              bad_counter;
  wire  logic [31:0] group_value;

  // Register pair addressing, n low and n+1 high
  assign reg_rd_addr_lo = reg_num;
  assign reg_rd_addr_hi = 16'(reg_num + 16'h0001);

  // One lane per nibble of the widest group
  for (genvar k = 0; k < paf_pkg::GROUP_MAX_32; k++) begin : g_lane
    paf_nibble_lane #(
      .LANE    (k),
      .NIB_W   (paf_pkg::NIBBLE_W),
      .COUNT_W (paf_pkg::GROUP_CNT_W)
    ) u_paf_nibble_lane (
      .group_count (nibble_group_operand),
      .bits_in     (bit_devices[k*paf_pkg::NIBBLE_W +: paf_pkg::NIBBLE_W]),
      .bits_out    (group_value[k*paf_pkg::NIBBLE_W +: paf_pkg::NIBBLE_W])
    );
  end

  always_comb begin
    // Width decides the group limit, the register pair and the constant extension
    if (width_prefix) begin
      group_limit = 4'(paf_pkg::GROUP_MAX_32);
      reg_pair    = {reg_rd_data_hi, reg_rd_data_lo};
      const_ext   = const_value;
    end else begin
      group_limit = 4'(paf_pkg::GROUP_MAX_16);
      reg_pair    = {16'h0000, reg_rd_data_lo};
      const_ext   = {{16{const_value[15]}}, const_value[15:0]};
    end
    // Operand refusals
    bad_group = (src_sel == paf_pkg::paf_src_group) &&
                ((nibble_group_operand == 4'h0) ||
                 (nibble_group_operand > group_limit));
    bad_counter = (src_sel == paf_pkg::paf_src_reg) &&
                  (src_kind == paf_pkg::paf_kind_counter) &&
                  !width_prefix &&
                  (reg_num >= paf_pkg::CNT32_FIRST) &&
                  (reg_num <= paf_pkg::CNT32_LAST);
    // Source select
    unique case (src_sel)
      paf_pkg::paf_src_const: begin
        src_value = const_ext;
      end
      paf_pkg::paf_src_group: begin
        src_value = group_value;
      end
      paf_pkg::paf_src_reg: begin
        src_value = reg_pair;
      end
      default: begin
        src_value = 32'h0000_0000;
      end
    endcase
  end

  // Scan gate: pulse slots fire on a rise only, continuous slots on every strobe with the contact on
  always_comb begin
    logic on_now;
    logic fire;
    on_now = drive_contact;
    fire = 1'b0;
    next_st = st;
    next_st.exec = 1'b0;
    if (scan_strobe) begin
      if (pulse_suffix) begin
        fire = on_now && !st.prev_on[instr_slot];
      end else begin
        fire = on_now;
      end
      // Edge memory follows the contact even when the operand is refused
      next_st.prev_on[instr_slot] = on_now;
      next_st.exec = fire && !bad_group && !bad_counter;
      next_st.is_double = width_prefix;
      next_st.operand_error = bad_group || bad_counter;
      if (fire) begin
        next_st.operand = src_value;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign exec          = st.exec;
  assign is_double     = st.is_double;
  assign operand       = st.operand;
  assign operand_error = st.operand_error;

endmodule : paf_front_end

// One four-bit lane of a grouped operand
module paf_nibble_lane #(
  parameter int unsigned LANE    = 0,
  parameter int unsigned NIB_W   = 4,
  parameter int unsigned COUNT_W = 4
) (
  input  wire logic [COUNT_W-1:0] group_count,
  input  wire logic [NIB_W-1:0]   bits_in,
  output logic      [NIB_W-1:0]   bits_out
);

  logic live;

  // Refuse a lane index that the group count width cannot represent, and a nibble width below one
  if (LANE >= (1 << COUNT_W)) begin : g_lane_range
    $error("LANE cannot be reached by the group count");
  end
  if (NIB_W < 1) begin : g_nib_width
    $error("NIB_W must be at least one");
  end

  // Lane k is live when the count exceeds k; dead lanes read as zero
  always_comb begin
    live     = (COUNT_W'(LANE) < group_count);
    bits_out = live ? bits_in : '0;
  end

endmodule : paf_nibble_lane

`default_nettype wire

/* File: design/paf_pkg.sv */
/*
  Constants for the application-instruction execution front end.
  Assumes one scan strobe per program scan from the scan sequencer.
*/
package paf_pkg;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned DWORD_W    = 32;
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned GROUP_MAX_16 = 4;
  localparam int unsigned GROUP_MAX_32 = 8;
  localparam int unsigned GROUP_CNT_W  = 4;
  localparam int unsigned REG_NUM_W    = 16;
  localparam logic [15:0] CNT32_FIRST  = 16'h00C8;
  localparam logic [15:0] CNT32_LAST   = 16'h00FF;
  localparam logic [15:0] CNT16_LAST   = 16'h00C7;

  typedef enum logic [1:0] {
    paf_src_const,
    paf_src_group,
    paf_src_reg
  } paf_src_t;

  typedef enum logic [1:0] {
    paf_kind_data,
    paf_kind_timer,
    paf_kind_counter
  } paf_kind_t;
endpackage : paf_pkg

/* File: sim/paf_front_end_asserts.sv */
/* Port assertions for paf_front_end.
   Bound to every instance at the foot. */
`timescale 1ns/100ps
`default_nettype none
module paf_front_end_asserts #(parameter int unsigned SLOTS = 8) (
  input wire logic ref_clk, rst, scan_strobe, width_prefix, pulse_suffix, drive_contact,
  input wire logic exec, is_double, operand_error,
  input wire logic [$clog2(SLOTS)-1:0] instr_slot,
  input wire logic [15:0] reg_num, reg_rd_addr_hi
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_hit; scan_strobe && pulse_suffix && drive_contact; endsequence
  sequence s_held; s_hit ##1 s_hit ##0 $stable(instr_slot); endsequence
  a_pulse_held: assert property (s_held |=> !exec) else $error("refire");
  a_idle_quiet: assert property (!scan_strobe |=> !exec && !operand_error) else $error("idle");
  a_off_blocks: assert property (scan_strobe && !drive_contact |=> !exec) else $error("off");
  a_cont_fires: assert property (scan_strobe && !pulse_suffix && drive_contact
    |=> exec || operand_error) else $error("cont");
  a_width_follow: assert property (scan_strobe |=> is_double == $past(width_prefix)) else $error("w");
  a_width_holds: assert property (!scan_strobe |=> $stable(is_double)) else $error("hold");
  a_pair_addr: assert property (reg_rd_addr_hi == reg_num + 16'h1) else $error("pair");
  a_err_quiet: assert property (operand_error |-> !exec) else $error("err");
endmodule : paf_front_end_asserts
bind paf_front_end paf_front_end_asserts #(.SLOTS(SLOTS)) u_chk (.*);
`default_nettype wire

/* File: sim/paf_front_end_tb.sv */
/* Bench for paf_front_end.
   Needs paf_pkg and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module paf_front_end_tb;
  logic ref_clk = 0, rst = 1, scan_strobe = 0, width_prefix = 0, pulse_suffix = 0;
  logic drive_contact = 0, exec, is_double, operand_error;
  logic [2:0] instr_slot = 0;
  logic [3:0] nibble_group_operand = 0;
  logic [15:0] reg_num = 0, reg_rd_addr_lo, reg_rd_addr_hi;
  logic [31:0] const_value = 0, bit_devices = 0, operand;
  paf_pkg::paf_src_t src_sel = paf_pkg::paf_src_const;
  paf_pkg::paf_kind_t src_kind = paf_pkg::paf_kind_data;
  int n_errors, check_count;
  wire [15:0] reg_rd_data_lo = {reg_rd_addr_lo[7:0], 8'hA5}, reg_rd_data_hi = {reg_rd_addr_hi[7:0], 8'hA5};
  paf_front_end u_paf_front_end (.*);
  initial forever #25 ref_clk = ~ref_clk;
  task chk(input logic [34:0] s, e);
    check_count++;
    n_errors += int'(s !== e);
    if (s !== e) $display("BAD %0t %h %h", $time, s, e);
  endtask : chk
  task stop_test;
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task go(input logic [5:0] f, input logic [1:0] s, input logic [31:0] v, input logic [34:0] e);
    {instr_slot, width_prefix, pulse_suffix, drive_contact} = f;
    src_sel = paf_pkg::paf_src_t'(s);
    {const_value, bit_devices, reg_num, nibble_group_operand} = {v, v, v[15:0], v[3:0]};
    scan_strobe = 1;
    @(posedge ref_clk) #1;
    chk({exec, operand_error, is_double, exec ? operand : 32'h0}, e);
  endtask : go
  task idle(input logic d);
    scan_strobe = 0;
    @(posedge ref_clk) #1;
    chk({exec, operand_error, is_double}, {2'b00, d});
  endtask : idle
  task t_exec;
    go(6'o05, 2'd0, 32'h80000000, 35'h580000000);
    idle(1'b1);
    go(6'o23, 2'd0, 32'h7, 35'h400000007);
    go(6'o23, 2'd0, 32'h9, 35'h0);
    go(6'o13, 2'd0, 32'h4, 35'h400000004);
    go(6'o22, 2'd0, 32'h9, 35'h0);
    go(6'o23, 2'd0, 32'h3, 35'h400000003);
    go(6'o01, 2'd0, 32'h8001, 35'h4FFFF8001);
    idle(1'b0);
  endtask : t_exec
  task t_operand;
    go(6'o01, 2'd1, 32'h123456A2, 35'h4000000A2);
    go(6'o01, 2'd1, 32'h5, 35'h200000000);
    go(6'o01, 2'd1, 32'h10, 35'h200000000);
    go(6'o05, 2'd1, 32'h9, 35'h300000000);
    go(6'o05, 2'd1, 32'hFEDCBA98, 35'h5FEDCBA98);
    go(6'o05, 2'd1, 32'hFFFFFF03, 35'h500000F03);
    go(6'o05, 2'd2, 32'hA, 35'h50BA50AA5);
    src_kind = paf_pkg::paf_kind_counter;
    go(6'o01, 2'd2, 32'hC8, 35'h200000000);
    go(6'o05, 2'd2, 32'hC8, 35'h5C9A5C8A5);
    go(6'o01, 2'd2, 32'hC7, 35'h40000C7A5);
    idle(1'b0);
  endtask : t_operand
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 0;
    @(posedge ref_clk) #1;
    chk({exec, operand_error, is_double, operand}, 35'h0);
    t_exec();
    t_operand();
    stop_test();
  end
  initial begin
    #10000;
    n_errors++;
    stop_test();
  end
endmodule : paf_front_end_tb
`default_nettype wire
